/* hdl/region_access_checker.sv */
// region access checker: eight prioritised protection regions over the core access stream
// assumes accesses and register strobes are synchronous to core_clk_in; the core
// holds back a write while the combinational fault answer is high
`timescale 1ns/10ps
`default_nettype none
`include "region_access_checker_defs.svh"

module region_access_checker
#(
   parameter int NUM_REGIONS = `RAC_NUM_REGIONS
)
(
   input  wire logic                                core_clk_in,
   input  wire logic                                rst_b_in,
   input  wire region_access_checker_pkg::access_req_t  access_in,
   output var  region_access_checker_pkg::access_resp_t resp_out,
   input  wire logic [5:0]                          reg_addr_in,
   input  wire logic [31:0]                         reg_wdata_in,
   input  wire logic                                reg_wr_in,
   input  wire logic                                reg_rd_in,
   input  wire logic                                reg_priv_in,
   output      logic [31:0]                         reg_rdata_out,
   output      logic                                mem_fault_out,
   output      logic                                irq_out
);
   import region_access_checker_pkg::*;

   logic [1:0]   ctrl_r;
   region_cfg_t  cfg_r [NUM_REGIONS];
   logic [1:0]   status_r;
   logic [1:0]   mask_r;
   logic [31:0]  fault_addr_r;
   logic [3:0]   fault_info_r;
   logic [31:0]  reg_rdata_r;
   logic [NUM_REGIONS-1:0] hit;

   wire logic prot_en     = ctrl_r[`RAC_CTRL_ENABLE_BIT];
   wire logic default_ok  = ctrl_r[`RAC_CTRL_DEFAULT_BIT];
   wire logic cfg_wr      = reg_wr_in & reg_priv_in;

   // region hit detection, one comparator per region
   genvar g;
   generate
      for (g = 0; g < NUM_REGIONS; g++)
      begin : g_hit
         logic [31:0] span_mask;
         assign span_mask = ~(32'hffff_ffff << cfg_r[g].size_log2);
         assign hit[g] = cfg_r[g].en &&
                         ((access_in.addr & ~span_mask) == (cfg_r[g].start & ~span_mask));
      end
   endgenerate

   logic        any_hit;
   region_cfg_t win;
   always_comb
   begin
      any_hit = 1'b0;
      win     = cfg_r[0];
      for (int i = 0; i < NUM_REGIONS; i++)
      begin
         if (hit[i])
         begin
            any_hit = 1'b1;
            win     = cfg_r[i];
         end
      end
   end

   logic rd_ok;
   logic wr_ok;
   always_comb
   begin
      rd_ok = 1'b0;
      wr_ok = 1'b0;
      case (win.perm)
         AP_NONE_NONE:
         begin
            rd_ok = 1'b0;
            wr_ok = 1'b0;
         end
         AP_RW_NONE:
         begin
            rd_ok = !access_in.unpriv;
            wr_ok = !access_in.unpriv;
         end
         AP_RW_RO:
         begin
            rd_ok = 1'b1;
            wr_ok = !access_in.unpriv;
         end
         AP_RW_RW:
         begin
            rd_ok = 1'b1;
            wr_ok = 1'b1;
         end
         AP_RO_NONE:
         begin
            rd_ok = !access_in.unpriv;
            wr_ok = 1'b0;
         end
         AP_RO_RO:
         begin
            rd_ok = 1'b1;
            wr_ok = 1'b0;
         end
         default:
         begin
            rd_ok = 1'b0;
            wr_ok = 1'b0;
         end
      endcase
   end

   logic allow;
   logic mismatch;
   always_comb
   begin
      mismatch = 1'b0;
      allow    = 1'b0;
      if (!prot_en)
      begin
         allow = 1'b1;
      end
      else if (!any_hit)
      begin
         allow    = default_ok;
         mismatch = !default_ok;
      end
      else
      begin
         case (access_in.op)
            OP_READ:  allow = rd_ok;
            OP_WRITE: allow = wr_ok;
            OP_EXEC:  allow = rd_ok && !win.xn;
            default:  allow = 1'b0;
         endcase
      end
   end

   assign resp_out.grant    = access_in.valid && allow;
   assign resp_out.fault    = access_in.valid && !allow;
   assign resp_out.mismatch = access_in.valid && mismatch;
   // fault line to the core handler
   assign mem_fault_out     = resp_out.fault;

   // permissive reset: protection off so every access is granted, regions disabled
   always_ff @(posedge core_clk_in)
   begin
      if (!rst_b_in)
         ctrl_r <= `RAC_CTRL_RESET;
      else if (cfg_wr && reg_addr_in == `RAC_ADDR_CTRL)
         ctrl_r <= reg_wdata_in[1:0];
   end

   generate
      for (g = 0; g < NUM_REGIONS; g++)
      begin : g_cfg
         always_ff @(posedge core_clk_in)
         begin
            if (!rst_b_in)
            begin
               cfg_r[g].en        <= 1'b0;
               cfg_r[g].xn        <= 1'b1;
               cfg_r[g].perm      <= AP_NONE_NONE;
               cfg_r[g].size_log2 <= `RAC_MIN_SIZE_LOG2;
               cfg_r[g].start     <= `RAC_START_RESET;
            end
            else if (cfg_wr && reg_addr_in == 6'(`RAC_ADDR_REGION_BASE + g))
               cfg_r[g].start <= reg_wdata_in;
            else if (cfg_wr && reg_addr_in == 6'(`RAC_ADDR_ATTR_BASE + g))
            begin
               cfg_r[g].en        <= reg_wdata_in[`RAC_ATTR_EN_BIT];
               cfg_r[g].xn        <= reg_wdata_in[`RAC_ATTR_XN_BIT];
               cfg_r[g].perm      <= perm_code_t'(reg_wdata_in[`RAC_ATTR_AP_LSB +: 3]);
               // sizes below the minimum would split sub-granule; clamp keeps compares sane
               cfg_r[g].size_log2 <= (reg_wdata_in[`RAC_ATTR_SIZE_LSB +: 5] < `RAC_MIN_SIZE_LOG2)
                                     ? `RAC_MIN_SIZE_LOG2 : reg_wdata_in[`RAC_ATTR_SIZE_LSB +: 5];
            end
         end
      end
   endgenerate

   // sticky fault status: a new event wins over a write-one clear
   logic [1:0] ev;
   assign ev = {resp_out.fault && !resp_out.mismatch, resp_out.mismatch};
   always_ff @(posedge core_clk_in)
   begin
      if (!rst_b_in)
         status_r <= 2'h0;
      else if (reg_wr_in && reg_addr_in == `RAC_ADDR_STATUS)
         status_r <= (status_r & ~reg_wdata_in[1:0]) | ev;
      else
         status_r <= status_r | ev;
   end

   always_ff @(posedge core_clk_in)
   begin
      if (!rst_b_in)
         mask_r <= 2'h0;
      else if (cfg_wr && reg_addr_in == `RAC_ADDR_MASK)
         mask_r <= reg_wdata_in[1:0];
   end

   // faulting address and kind of the latest denied access
   always_ff @(posedge core_clk_in)
   begin
      if (!rst_b_in)
      begin
         fault_addr_r <= 32'h0;
         fault_info_r <= 4'h0;
      end
      else if (resp_out.fault)
      begin
         fault_addr_r <= access_in.addr;
         fault_info_r <= {access_in.unpriv, 1'b0, access_in.op};
      end
   end

   assign irq_out = |(status_r & mask_r);

   always_ff @(posedge core_clk_in)
   begin
      if (!rst_b_in)
         reg_rdata_r <= 32'h0;
      else if (reg_rd_in)
      begin
         reg_rdata_r <= 32'h0;
         case (reg_addr_in)
            `RAC_ADDR_CTRL:       reg_rdata_r <= {30'h0, ctrl_r};
            `RAC_ADDR_STATUS:     reg_rdata_r <= {30'h0, status_r};
            `RAC_ADDR_MASK:       reg_rdata_r <= {30'h0, mask_r};
            `RAC_ADDR_FAULT_ADDR: reg_rdata_r <= fault_addr_r;
            `RAC_ADDR_FAULT_INFO: reg_rdata_r <= {28'h0, fault_info_r};
            default:
            begin
               for (int i = 0; i < NUM_REGIONS; i++)
               begin
                  if (reg_addr_in == 6'(`RAC_ADDR_REGION_BASE + i))
                     reg_rdata_r <= cfg_r[i].start;
                  if (reg_addr_in == 6'(`RAC_ADDR_ATTR_BASE + i))
                     reg_rdata_r <= {19'h0, cfg_r[i].size_log2, 1'b0, cfg_r[i].perm,
                                     2'h0, cfg_r[i].xn, cfg_r[i].en};
               end
            end
         endcase
      end
      else
         reg_rdata_r <= 32'h0;
   end
   assign reg_rdata_out = reg_rdata_r;

   // assertions
   a_disabled_grants_all:
   assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
      (!prot_en && access_in.valid) |-> resp_out.grant)
      else $error("access refused while protection off");

   a_grant_fault_excl:
   assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
      !(resp_out.grant && resp_out.fault))
      else $error("grant and fault together");

   a_xn_blocks_exec:
   assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
      (prot_en && any_hit && win.xn && access_in.valid && access_in.op == OP_EXEC)
      |-> resp_out.fault)
      else $error("execute granted in no-execute region");

   a_none_faults_all:
   assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
      (prot_en && any_hit && win.perm == AP_NONE_NONE && access_in.valid) |-> mem_fault_out)
      else $error("no-access region granted");

   a_user_ro_write:
   assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
      (prot_en && any_hit && win.perm == AP_RW_RO && access_in.valid && access_in.unpriv
       && access_in.op == OP_WRITE) |-> resp_out.fault)
      else $error("user write granted in read-only region");

   a_priv_ro_write:
   assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
      (prot_en && any_hit && win.perm == AP_RO_NONE && access_in.valid
       && access_in.op == OP_WRITE) |-> resp_out.fault)
      else $error("write granted in privileged read-only region");

   a_default_region:
   assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
      (prot_en && !any_hit && access_in.valid) |-> (resp_out.grant == default_ok))
      else $error("default region verdict wrong");

   a_unpriv_no_cfg:
   assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
      (reg_wr_in && !reg_priv_in && reg_addr_in == `RAC_ADDR_CTRL) |=> $stable(ctrl_r))
      else $error("unprivileged write changed control");

   a_fault_sticky:
   assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
      resp_out.fault |=> (status_r != 2'h0))
      else $error("fault not recorded");

endmodule
`default_nettype wire

/* hdl/region_access_checker_defs.svh */
// constants for the region access checker: register indices, field positions, reset values
// assumes a 32-bit register port with word indices and a 32-bit access address
`ifndef REGION_ACCESS_CHECKER_DEFS_SVH
`define REGION_ACCESS_CHECKER_DEFS_SVH

`define RAC_NUM_REGIONS      8
`define RAC_ADDR_CTRL        6'h00
`define RAC_ADDR_STATUS      6'h01
`define RAC_ADDR_MASK        6'h02
`define RAC_ADDR_FAULT_ADDR  6'h03
`define RAC_ADDR_FAULT_INFO  6'h04
`define RAC_ADDR_REGION_BASE 6'h10
`define RAC_ADDR_ATTR_BASE   6'h18
`define RAC_CTRL_ENABLE_BIT  0
`define RAC_CTRL_DEFAULT_BIT 1
`define RAC_ATTR_EN_BIT      0
`define RAC_ATTR_XN_BIT      1
`define RAC_ATTR_AP_LSB      4
`define RAC_ATTR_SIZE_LSB    8
`define RAC_ST_MISMATCH_BIT  0
`define RAC_ST_PERM_BIT      1
`define RAC_CTRL_RESET       2'h0
`define RAC_ATTR_RESET       32'h0000_0000
`define RAC_START_RESET      32'h0000_0000
`define RAC_MIN_SIZE_LOG2    5'h04

`endif

/* hdl/region_access_checker_pkg.sv */
// types shared by the region access checker and its bench
// assumes the constants header is included alongside
package region_access_checker_pkg;

   typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_EXEC} access_op_t;

   // permission matrix codes, privileged/user
   typedef enum logic [2:0]
   {
      AP_NONE_NONE,
      AP_RW_NONE,
      AP_RW_RO,
      AP_RW_RW,
      AP_RO_NONE,
      AP_RO_RO
   } perm_code_t;

   typedef struct packed
   {
      logic        valid;
      logic [31:0] addr;
      access_op_t  op;
      logic        unpriv;
   } access_req_t;

   typedef struct packed
   {
      logic        grant;
      logic        fault;
      logic        mismatch;
   } access_resp_t;

   typedef struct packed
   {
      logic        en;
      logic        xn;
      perm_code_t  perm;
      logic [4:0]  size_log2;
      logic [31:0] start;
   } region_cfg_t;

endpackage

/* verif/core_access_model.sv */
// core access model: presents one access per go pulse, performs writes only when granted
// assumes the bench pulses go for one cycle and the checker answers in the cycle the access is presented
`timescale 1ns/10ps
`default_nettype none

module core_access_model
(
   input  wire logic                                  core_clk_in,
   input  wire logic                                  rst_b_in,
   input  wire logic                                  go_in,
   input  wire logic [31:0]                           addr_in,
   input  wire region_access_checker_pkg::access_op_t op_in,
   input  wire logic                                  unpriv_in,
   input  wire region_access_checker_pkg::access_resp_t resp_in,
   output var region_access_checker_pkg::access_req_t req_out,
   output var logic [7:0]                             wr_done_out
);
   import region_access_checker_pkg::*;

   always_ff @(posedge core_clk_in)
   begin
      if (!rst_b_in)
         req_out <= '0;
      else if (go_in)
         req_out <= '{valid: 1'b1, addr: addr_in, op: op_in, unpriv: unpriv_in};
      else
         // released address and unpriv lines invert, op holds, so a stale address never looks held
         req_out <= '{valid: 1'b0, addr: ~req_out.addr, op: req_out.op, unpriv: ~req_out.unpriv};
   end

   always_ff @(posedge core_clk_in)
   begin
      if (!rst_b_in)
         wr_done_out <= 8'h00;
      else if (req_out.valid && req_out.op == OP_WRITE && resp_in.grant && !resp_in.fault)
         wr_done_out <= wr_done_out + 8'h01;
   end
endmodule
`default_nettype wire

/* verif/region_access_checker_tb.sv */
// bench for the region access checker: register tasks, core model, access scenarios
// assumes the core model holds each access for one cycle and counts performed writes
`timescale 1ns/10ps
`default_nettype none
`include "region_access_checker_defs.svh"

module region_access_checker_tb;
   import region_access_checker_pkg::*;
   logic         clk;
   logic         rst_b;
   logic [5:0]   ra;
   logic [31:0]  wd;
   logic         wr;
   logic         rd;
   logic         priv;
   logic         go;
   logic         up;
   logic [31:0]  aa;
   access_op_t   op;
   access_req_t  req;
   access_resp_t resp;
   logic [31:0]  rdata;
   logic         mfault;
   logic         irq;
   logic [7:0]   wr_done;
   int           fail_count;
   int           n_checks;
   int           cyc;

   region_access_checker region_access_checker_i (.core_clk_in(clk), .rst_b_in(rst_b),
      .access_in(req), .resp_out(resp), .reg_addr_in(ra), .reg_wdata_in(wd), .reg_wr_in(wr),
      .reg_rd_in(rd), .reg_priv_in(priv), .reg_rdata_out(rdata), .mem_fault_out(mfault),
      .irq_out(irq));
   core_access_model core_access_model_i (.core_clk_in(clk), .rst_b_in(rst_b), .go_in(go),
      .addr_in(aa), .op_in(op), .unpriv_in(up), .resp_in(resp), .req_out(req),
      .wr_done_out(wr_done));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic wreg(input logic [5:0] a, input logic [31:0] d, input logic p);
      ra <= a;
      wd <= d;
      priv <= p;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rreg(input logic [5:0] a, input logic [31:0] exp, input string what);
      ra <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdata, exp, what);
      @(posedge clk);
   endtask

   // one access through the core model, verdict judged in its own cycle
   task automatic acc(input logic [31:0] a, input access_op_t o, input logic u,
                      input logic f, input logic m);
      aa <= a;
      op <= o;
      up <= u;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      #1 chk({resp.fault, resp.grant, resp.mismatch, mfault}, {f, !f, m, f}, "access");
      @(posedge clk);
   endtask

   // execute follows read unless no-execute is set
   function automatic logic deny(input int c, input int x, input access_op_t o, input logic u);
      logic r;
      logic w;
      r = u ? (c == 2 || c == 3 || c == 5) : (c >= 1 && c <= 5);
      w = u ? (c == 3) : (c >= 1 && c <= 3);
      return o == OP_WRITE ? !w : (o == OP_READ ? !r : !(r && x == 0));
   endfunction

   task automatic t_reset();
      rreg(`RAC_ADDR_CTRL, 32'h0, "ctrl");
      rreg(`RAC_ADDR_ATTR_BASE, 32'h0000_0402, "attr");
      rreg(`RAC_ADDR_MASK, 32'h0, "mask");
      for (int i = 0; i < 6; i++)
         acc(32'h0000_1000 * i, access_op_t'(i % 3), i >= 3, 1'b0, 1'b0);
      $display("test reset done");
   endtask

   task automatic t_cfg();
      wreg(`RAC_ADDR_CTRL, 32'h3, 1'b0);
      rreg(`RAC_ADDR_CTRL, 32'h0, "user ctrl");
      wreg(`RAC_ADDR_CTRL, 32'h1, 1'b1);
      rreg(`RAC_ADDR_CTRL, 32'h1, "priv ctrl");
      acc(32'h8000_0000, OP_READ, 1'b0, 1'b1, 1'b1);
      rreg(`RAC_ADDR_STATUS, 32'h1, "mismatch");
      wreg(`RAC_ADDR_CTRL, 32'h3, 1'b1);
      acc(32'h8000_0000, OP_WRITE, 1'b1, 1'b0, 1'b0);
      wreg(`RAC_ADDR_STATUS, 32'h3, 1'b0);
      rreg(`RAC_ADDR_STATUS, 32'h0, "w1c");
      $display("test config done");
   endtask

   task automatic t_perm();
      logic [7:0] w0;
      logic [7:0] n;
      logic       f;
      w0 = wr_done;
      n = 8'h00;
      wreg(`RAC_ADDR_REGION_BASE, 32'h0000_1000, 1'b1);
      // codes six and seven are spare and must behave as no access
      for (int c = 0; c < 8; c++)
         for (int x = 0; x < 2; x++)
         begin
            wreg(`RAC_ADDR_ATTR_BASE, 32'h0c01 | 32'(x << 1) | 32'(c << 4), 1'b1);
            for (int k = 0; k < 6; k++)
            begin
               f = deny(c, x, access_op_t'(k % 3), k >= 3);
               if (k % 3 == 1 && !f)
                  n++;
               acc(32'h0000_1ffc, access_op_t'(k % 3), k >= 3, f, 1'b0);
            end
         end
      chk(wr_done - w0, n, "writes done");
      $display("test perm done");
   endtask

   task automatic t_prio();
      wreg(`RAC_ADDR_ATTR_BASE, 32'h0c31, 1'b1);
      wreg(6'h17, 32'h0000_1000, 1'b1);
      wreg(6'h1f, 32'h0401, 1'b1);
      acc(32'h0000_1004, OP_READ, 1'b0, 1'b1, 1'b0);
      acc(32'h0000_1800, OP_READ, 1'b0, 1'b0, 1'b0);
      wreg(6'h13, 32'h0000_1000, 1'b1);
      wreg(6'h1b, 32'h0431, 1'b1);
      acc(32'h0000_1004, OP_EXEC, 1'b0, 1'b1, 1'b0);
      wreg(6'h1f, 32'h0400, 1'b1);
      acc(32'h0000_1004, OP_EXEC, 1'b0, 1'b0, 1'b0);
      $display("test prio done");
   endtask

   task automatic t_irq();
      wreg(`RAC_ADDR_STATUS, 32'h3, 1'b1);
      wreg(6'h1f, 32'h0401, 1'b1);
      acc(32'h0000_1008, OP_WRITE, 1'b1, 1'b1, 1'b0);
      rreg(`RAC_ADDR_FAULT_ADDR, 32'h0000_1008, "fault addr");
      rreg(`RAC_ADDR_FAULT_INFO, 32'h9, "fault info");
      rreg(`RAC_ADDR_STATUS, 32'h2, "perm status");
      chk(irq, 1'b0, "irq masked");
      wreg(`RAC_ADDR_MASK, 32'h2, 1'b1);
      #1 chk(irq, 1'b1, "irq on");
      @(posedge clk);
      wreg(`RAC_ADDR_STATUS, 32'h2, 1'b0);
      #1 chk(irq, 1'b0, "irq clear");
      @(posedge clk);
      rreg(6'h3f, 32'h0, "unmapped");
      $display("test irq done");
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // the whole run needs well under a thousand cycles
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         fail_count++;
         final_report();
      end
   end

   initial
   begin
      {rst_b, ra, wd, wr, rd, priv, go, up, aa} = '0;
      op = OP_READ;
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      t_reset();
      t_cfg();
      t_perm();
      t_prio();
      t_irq();
      final_report();
   end
endmodule
`default_nettype wire
